// file: pkg/bioh_bus_if.sv
// interface: the byte i/o bus wires between host and one device controller
`timescale 1ns/1ps
interface bioh_bus_if;
    logic [7:0] outbound_data_lines;
    logic address_strobe;
    logic command_strobe;
    logic data_out_strobe;
    logic status_request_strobe;
    logic data_request_strobe;
    logic ack_in;
    logic spare_ctl6;
    logic spare_ctl7;
    logic system_clear;
    logic [7:0] inbound_data_lines;
    logic sync_response;
    logic attention_request;
    logic ack_out;

    modport host (
        output outbound_data_lines, address_strobe, command_strobe, data_out_strobe,
        output status_request_strobe, data_request_strobe, ack_in, spare_ctl6, spare_ctl7,
        output system_clear,
        input inbound_data_lines, sync_response, attention_request
    );
    modport device (
        input outbound_data_lines, address_strobe, command_strobe, data_out_strobe,
        input status_request_strobe, data_request_strobe, ack_in, spare_ctl6, spare_ctl7,
        input system_clear,
        output inbound_data_lines, sync_response, attention_request, ack_out
    );
endinterface : bioh_bus_if

// file: pkg/bioh_pkg.sv
// package: shared constants and types of the byte i/o bus handshake
package bioh_pkg;
    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned BUS_LINE_COUNT = 27;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned MAX_DEVICES = 256;
    localparam logic [7:0] DEV_NUM_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // host operations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        BIOH_OP_ADDRESS,
        BIOH_OP_COMMAND,
        BIOH_OP_DATA_OUT,
        BIOH_OP_STATUS_REQ,
        BIOH_OP_DATA_REQ,
        BIOH_OP_ACK
    } bioh_op_e;
endpackage : bioh_pkg

// file: rtl/bioh_device.sv
// device controller end of the byte i/o bus handshake
`timescale 1ns/1ps
// Contract
// - bus has twenty-seven lines in fixed groups
// - up to 256 controllers, eight-bit numbers
// - host qualifies outbound byte by strobe
// - device drives inbound byte when requested
// - status request: status byte, then sync
// - data request: data byte, then sync
// - acknowledge: own number, then sync
// - host sets data before data strobe
// - command byte with command strobe
// - device number with address strobe selects
// - attention held until acknowledge arrives
// - every strobe answered by sync; device gives none to a foreign address, a passed ack, or a command, data or status strobe while unaddressed
// - system clear resets every controller
// - acknowledge chained; pending blocks, otherwise passes
// - address match answers sync, becomes addressed
// - addressed until other address or clear
// - output sync only after byte accepted
// - input sync marks inbound byte valid
// - queue flip-flop drives attention always
// - first pending controller on chain answers
module bioh_device #(
    parameter logic [7:0] DEV_NUM = bioh_pkg::DEV_NUM_RESET
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // bus side
    bioh_bus_if.device bus,
    // user side
    input wire logic i_irq_set,
    input wire logic [7:0] i_status,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_ready,
    input wire logic i_wr_ready,
    output logic [7:0] o_wr_data,
    output logic o_wr_valid,
    output logic [7:0] o_cmd,
    output logic o_cmd_valid,
    output logic o_addressed,
    output logic o_irq_pending
);
    typedef enum logic [2:0] {
        BIOH_DEV_IDLE,
        BIOH_DEV_SYNC,
        BIOH_DEV_PASS,
        BIOH_DEV_IGNORE
    } bioh_dev_state_e;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int unsigned NSYNC = 8;
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [7:0] obyte_s1_r;
    logic [7:0] obyte_s2_r;
    assign raw_w = {bus.system_clear, bus.ack_in, bus.data_request_strobe,
                    bus.status_request_strobe, bus.data_out_strobe,
                    bus.command_strobe, bus.address_strobe, 1'b0};
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_r <= '0;
            s2_r <= '0;
            obyte_s1_r <= bioh_pkg::BYTE_RESET;
            obyte_s2_r <= bioh_pkg::BYTE_RESET;
        end else begin
            s1_r <= raw_w;
            s2_r <= s1_r;
            obyte_s1_r <= bus.outbound_data_lines;
            obyte_s2_r <= obyte_s1_r;
        end
    end
    logic adr_w, cmd_w, dao_w, stat_w, dreq_w, ack_w, clr_w, any_w;
    assign {clr_w, ack_w, dreq_w, stat_w, dao_w, cmd_w, adr_w} = s2_r[NSYNC-1:1];
    assign any_w = adr_w | cmd_w | dao_w | stat_w | dreq_w | ack_w;

    // ----------------------------------------------------------------
    // handshake state
    // ----------------------------------------------------------------
    bioh_dev_state_e st_r, st_nxt;
    logic addr_r, addr_nxt;
    logic queue_r, queue_nxt;
    logic sync_r, sync_nxt;
    logic pass_r, pass_nxt;
    logic [7:0] ibyte_r, ibyte_nxt;
    logic [7:0] wr_r, wr_nxt;
    logic wrv_r, wrv_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic cmdv_r, cmdv_nxt;

    always_comb begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        queue_nxt = queue_r | i_irq_set;
        sync_nxt = sync_r;
        pass_nxt = pass_r;
        ibyte_nxt = ibyte_r;
        wr_nxt = wr_r;
        wrv_nxt = 1'b0;
        cmd_nxt = cmd_r;
        cmdv_nxt = 1'b0;
        case (st_r)
            BIOH_DEV_IDLE: begin
                if (ack_w) begin
                    if (queue_r) begin
                        ibyte_nxt = DEV_NUM;
                        sync_nxt = 1'b1;
                        queue_nxt = i_irq_set;
                        st_nxt = BIOH_DEV_SYNC;
                    end else begin
                        pass_nxt = 1'b1;
                        st_nxt = BIOH_DEV_PASS;
                    end
                end else if (adr_w) begin
                    if (obyte_s2_r == DEV_NUM) begin
                        addr_nxt = 1'b1;
                        sync_nxt = 1'b1;
                        st_nxt = BIOH_DEV_SYNC;
                    end else begin
                        addr_nxt = 1'b0;
                        st_nxt = BIOH_DEV_IGNORE;
                    end
                end else if (addr_r) begin
                    if (cmd_w) begin
                        cmd_nxt = obyte_s2_r;
                        cmdv_nxt = 1'b1;
                        sync_nxt = 1'b1;
                        st_nxt = BIOH_DEV_SYNC;
                    end else if (dao_w && i_wr_ready) begin
                        wr_nxt = obyte_s2_r;
                        wrv_nxt = 1'b1;
                        sync_nxt = 1'b1;
                        st_nxt = BIOH_DEV_SYNC;
                    end else if (stat_w) begin
                        ibyte_nxt = i_status;
                        sync_nxt = 1'b1;
                        st_nxt = BIOH_DEV_SYNC;
                    end else if (dreq_w && i_rd_ready) begin
                        ibyte_nxt = i_rd_data;
                        sync_nxt = 1'b1;
                        st_nxt = BIOH_DEV_SYNC;
                    end
                end else if (any_w) begin
                    st_nxt = BIOH_DEV_IGNORE;
                end
            end
            BIOH_DEV_SYNC: begin
                if (!any_w) begin
                    sync_nxt = 1'b0;
                    ibyte_nxt = bioh_pkg::BYTE_RESET;
                    st_nxt = BIOH_DEV_IDLE;
                end
            end
            BIOH_DEV_PASS: begin
                if (!ack_w) begin
                    pass_nxt = 1'b0;
                    st_nxt = BIOH_DEV_IDLE;
                end
            end
            default: begin
                if (!any_w) begin
                    st_nxt = BIOH_DEV_IDLE;
                end
            end
        endcase
        if (clr_w) begin
            st_nxt = BIOH_DEV_IDLE;
            addr_nxt = 1'b0;
            queue_nxt = 1'b0;
            sync_nxt = 1'b0;
            pass_nxt = 1'b0;
            ibyte_nxt = bioh_pkg::BYTE_RESET;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= BIOH_DEV_IDLE;
            addr_r <= 1'b0;
            queue_r <= 1'b0;
            sync_r <= 1'b0;
            pass_r <= 1'b0;
            ibyte_r <= bioh_pkg::BYTE_RESET;
            wr_r <= bioh_pkg::BYTE_RESET;
            wrv_r <= 1'b0;
            cmd_r <= bioh_pkg::BYTE_RESET;
            cmdv_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            queue_r <= queue_nxt;
            sync_r <= sync_nxt;
            pass_r <= pass_nxt;
            ibyte_r <= ibyte_nxt;
            wr_r <= wr_nxt;
            wrv_r <= wrv_nxt;
            cmd_r <= cmd_nxt;
            cmdv_r <= cmdv_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // byte is registered on the same edge as sync, so it is valid when sync rises
    assign bus.inbound_data_lines = ibyte_r;
    assign bus.sync_response = sync_r;
    assign bus.attention_request = queue_r;
    assign bus.ack_out = pass_r;
    assign o_wr_data = wr_r;
    assign o_wr_valid = wrv_r;
    assign o_cmd = cmd_r;
    assign o_cmd_valid = cmdv_r;
    assign o_addressed = addr_r;
    assign o_irq_pending = queue_r;
endmodule : bioh_device // bioh_device

// file: rtl/bioh_host.sv
// processor end of the byte i/o bus handshake
`timescale 1ns/1ps
module bioh_host (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // bus side
    bioh_bus_if.host bus,
    // user side
    input wire logic i_req_valid,
    input wire bioh_pkg::bioh_op_e i_req_op,
    input wire logic [7:0] i_req_byte,
    input wire logic i_clear,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [7:0] o_rsp_byte,
    output logic o_attention
);
    typedef enum logic [1:0] {
        BIOH_HOST_IDLE,
        BIOH_HOST_SETUP,
        BIOH_HOST_WAIT,
        BIOH_HOST_DROP
    } bioh_host_state_e;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [7:0] ibyte_s1_r;
    logic [7:0] ibyte_s2_r;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            ibyte_s1_r <= bioh_pkg::BYTE_RESET;
            ibyte_s2_r <= bioh_pkg::BYTE_RESET;
        end else begin
            s1_r <= {bus.attention_request, bus.sync_response};
            s2_r <= s1_r;
            ibyte_s1_r <= bus.inbound_data_lines;
            ibyte_s2_r <= ibyte_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // strobe sequencer
    // ----------------------------------------------------------------
    bioh_host_state_e st_r, st_nxt;
    bioh_pkg::bioh_op_e op_r, op_nxt;
    logic [7:0] obyte_r, obyte_nxt;
    logic stb_r, stb_nxt;
    logic rspv_r, rspv_nxt;
    logic [7:0] rsp_r, rsp_nxt;
    logic clr_r, clr_nxt;

    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        obyte_nxt = obyte_r;
        stb_nxt = stb_r;
        rspv_nxt = 1'b0;
        rsp_nxt = rsp_r;
        clr_nxt = i_clear;
        case (st_r)
            BIOH_HOST_IDLE: begin
                if (i_req_valid && !i_clear) begin
                    op_nxt = i_req_op;
                    obyte_nxt = i_req_byte; // byte settles one edge before strobe
                    st_nxt = BIOH_HOST_SETUP;
                end
            end
            BIOH_HOST_SETUP: begin
                stb_nxt = 1'b1;
                st_nxt = BIOH_HOST_WAIT;
            end
            BIOH_HOST_WAIT: begin
                if (s2_r[0]) begin
                    rsp_nxt = ibyte_s2_r; // sync and the byte it qualifies pass the same two synchroniser stages
                    stb_nxt = 1'b0;
                    st_nxt = BIOH_HOST_DROP;
                end
            end
            default: begin
                if (!s2_r[0]) begin
                    rspv_nxt = 1'b1;
                    st_nxt = BIOH_HOST_IDLE;
                end
            end
        endcase
        if (i_clear) begin
            st_nxt = BIOH_HOST_IDLE;
            stb_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= BIOH_HOST_IDLE;
            op_r <= bioh_pkg::BIOH_OP_ADDRESS;
            obyte_r <= bioh_pkg::BYTE_RESET;
            stb_r <= 1'b0;
            rspv_r <= 1'b0;
            rsp_r <= bioh_pkg::BYTE_RESET;
            clr_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            obyte_r <= obyte_nxt;
            stb_r <= stb_nxt;
            rspv_r <= rspv_nxt;
            rsp_r <= rsp_nxt;
            clr_r <= clr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bus.outbound_data_lines = obyte_r;
    assign bus.address_strobe = stb_r && (op_r == bioh_pkg::BIOH_OP_ADDRESS);
    assign bus.command_strobe = stb_r && (op_r == bioh_pkg::BIOH_OP_COMMAND);
    assign bus.data_out_strobe = stb_r && (op_r == bioh_pkg::BIOH_OP_DATA_OUT);
    assign bus.status_request_strobe = stb_r && (op_r == bioh_pkg::BIOH_OP_STATUS_REQ);
    assign bus.data_request_strobe = stb_r && (op_r == bioh_pkg::BIOH_OP_DATA_REQ);
    assign bus.ack_in = stb_r && (op_r == bioh_pkg::BIOH_OP_ACK);
    assign bus.spare_ctl6 = 1'b0;
    assign bus.spare_ctl7 = 1'b0;
    assign bus.system_clear = clr_r;
    assign o_req_ready = (st_r == BIOH_HOST_IDLE) && !i_clear;
    assign o_rsp_valid = rspv_r;
    assign o_rsp_byte = rsp_r;
    assign o_attention = s2_r[1];
endmodule : bioh_host // bioh_host

// file: tb/bioh_sva.sv
// checker: properties on the bus wires between host and device ends
`timescale 1ns/1ps
module bioh_sva (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // host to device
    input wire logic [7:0] outbound_data_lines,
    input wire logic address_strobe,
    input wire logic command_strobe,
    input wire logic data_out_strobe,
    input wire logic status_request_strobe,
    input wire logic data_request_strobe,
    input wire logic ack_in,
    input wire logic system_clear,
    // device to host
    input wire logic [7:0] inbound_data_lines,
    input wire logic sync_response,
    input wire logic attention_request,
    input wire logic ack_out
);
    logic out_stb;
    logic any_stb;
    assign out_stb = address_strobe | command_strobe | data_out_strobe;
    assign any_stb = out_stb | status_request_strobe | data_request_strobe | ack_in;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // ----
    // properties
    // ----
    a_one_strobe: assert property ($onehot0({address_strobe, command_strobe,
        data_out_strobe, status_request_strobe, data_request_strobe, ack_in}))
        else $error("two strobes high");
    a_byte_first: assert property ($rose(out_stb) |-> $stable(outbound_data_lines))
        else $error("byte changed with strobe");
    a_byte_steady: assert property (out_stb && $past(out_stb) |->
        $stable(outbound_data_lines)) else $error("byte moved under strobe");
    a_sync_cause: assert property ($rose(sync_response) |->
        $past(any_stb, 1) && $past(any_stb, 2)) else $error("sync without strobe");
    a_sync_hold: assert property (disable iff (!i_nrst || system_clear)
        sync_response && any_stb |=> sync_response) else $error("sync dropped early");
    a_sync_release: assert property ($fell(any_stb) |-> ##[0:4] !sync_response)
        else $error("sync not released");
    a_in_steady: assert property (sync_response && $past(sync_response) |->
        $stable(inbound_data_lines)) else $error("inbound byte moved");
    a_atn_hold: assert property (disable iff (!i_nrst || system_clear)
        attention_request && !ack_in |=> attention_request) else $error("attention lost");
    a_ack_blocked: assert property (ack_out |-> !sync_response)
        else $error("ack passed and answered");
    a_ack_cause: assert property ($rose(sync_response) && ack_in |->
        $past(attention_request)) else $error("ack answered without pending");
    c_out: cover property ($rose(sync_response) && data_out_strobe);
    c_ack: cover property ($rose(sync_response) && ack_in);
    c_pass: cover property (ack_out);
endmodule // bioh_sva

// file: tb/tb_byte_io_bus_handshake.sv
// testbench: host and device ends joined through one bus interface
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_byte_io_bus_handshake;
    localparam logic [7:0] DEV = 8'h5A;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic req_valid = 1'b0, clear = 1'b0, irq_set = 1'b0, rd_ready = 1'b1, wr_ready = 1'b1;
    bioh_pkg::bioh_op_e req_op = bioh_pkg::BIOH_OP_ADDRESS;
    logic [7:0] req_byte = 8'h00, status = 8'h00, rd_data = 8'h00;
    logic req_ready, rsp_valid, attention, wr_valid, cmd_valid, addressed, irq_pending;
    logic [7:0] rsp_byte, wr_data, cmd, b, q;
    logic [7:0] got_wr[$], got_cmd[$];
    logic ok;
    bit m_addr = 1'b0;
    int errors = 0, n_tests = 0, seed = 25721, k, st;
    bioh_pkg::bioh_op_e ops[4] = '{bioh_pkg::BIOH_OP_COMMAND, bioh_pkg::BIOH_OP_DATA_OUT,
        bioh_pkg::BIOH_OP_STATUS_REQ, bioh_pkg::BIOH_OP_DATA_REQ};
    always #12.5 i_clock = ~i_clock;
    // ----
    // ends and checker
    // ----
    bioh_bus_if bus_if ();
    bioh_host bioh_host_inst (.i_clock(i_clock), .i_nrst(i_nrst), .bus(bus_if),
        .i_req_valid(req_valid), .i_req_op(req_op), .i_req_byte(req_byte), .i_clear(clear),
        .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_byte(rsp_byte),
        .o_attention(attention));
    bioh_device #(.DEV_NUM(DEV)) bioh_device_inst (.i_clock(i_clock), .i_nrst(i_nrst),
        .bus(bus_if), .i_irq_set(irq_set), .i_status(status), .i_rd_data(rd_data),
        .i_rd_ready(rd_ready), .i_wr_ready(wr_ready), .o_wr_data(wr_data),
        .o_wr_valid(wr_valid), .o_cmd(cmd), .o_cmd_valid(cmd_valid),
        .o_addressed(addressed), .o_irq_pending(irq_pending));
    bioh_sva bioh_sva_inst (.i_clock(i_clock), .i_nrst(i_nrst),
        .outbound_data_lines(bus_if.outbound_data_lines),
        .address_strobe(bus_if.address_strobe), .command_strobe(bus_if.command_strobe),
        .data_out_strobe(bus_if.data_out_strobe),
        .status_request_strobe(bus_if.status_request_strobe),
        .data_request_strobe(bus_if.data_request_strobe), .ack_in(bus_if.ack_in),
        .system_clear(bus_if.system_clear), .inbound_data_lines(bus_if.inbound_data_lines),
        .sync_response(bus_if.sync_response), .attention_request(bus_if.attention_request),
        .ack_out(bus_if.ack_out));
    always @(posedge i_clock) begin
        if (wr_valid === 1'b1) got_wr.push_back(wr_data);
        if (cmd_valid === 1'b1) got_cmd.push_back(cmd);
    end
    // ----
    // tasks
    // ----
    // ready lines are held low for stall+2 cycles when stall > 0, so sync for data out and data request waits for the user side when stall >= 3
    task automatic op(input bioh_pkg::bioh_op_e o, input logic [7:0] v, input int stall,
            input int lim);
        int i;
        @(posedge i_clock);
        req_valid <= 1'b1;
        req_op <= o;
        req_byte <= v;
        rd_ready <= (stall == 0);
        wr_ready <= (stall == 0);
        @(posedge i_clock);
        req_valid <= 1'b0;
        ok = 1'b0;
        for (i = 0; i < lim && !ok; i++) begin
            @(posedge i_clock);
            if (i == stall) begin
                rd_ready <= 1'b1;
                wr_ready <= 1'b1;
            end
            #1;
            ok = (rsp_valid === 1'b1);
        end
    endtask
    // system clear is the only way out of a strobe that no device answers
    task automatic abort();
        @(posedge i_clock);
        clear <= 1'b1;
        repeat (5) @(posedge i_clock);
        #1;
        `CHK(bus_if.system_clear, 1'b1)
        `CHK(req_ready, 1'b0)
        @(posedge i_clock);
        clear <= 1'b0;
        repeat (6) @(posedge i_clock);
        #1;
        m_addr = 1'b0;
        `CHK(req_ready, 1'b1)
    endtask
    task automatic summarize();
        $display("comparisons=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----
    // sequence
    // ----
    initial begin
        #500000;
        errors++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_nrst <= 1'b1;
        repeat (5) @(posedge i_clock);
        #1;
        `CHK(addressed, m_addr)
        `CHK(req_ready, 1'b1)
        op(bioh_pkg::BIOH_OP_ADDRESS, DEV ^ 8'h01, 0, 30);
        `CHK(ok, 1'b0)
        `CHK(addressed, m_addr)
        abort();
        op(bioh_pkg::BIOH_OP_ADDRESS, DEV, 0, 60);
        m_addr = 1'b1;
        `CHK(ok, 1'b1)
        `CHK(addressed, m_addr)
        for (k = 0; k < 24; k++) begin
            b = 8'($random(seed));
            st = $random(seed) & 7;
            @(posedge i_clock);
            status <= b;
            rd_data <= ~b;
            op(ops[k % 4], b, st, 80);
            `CHK(ok, 1'b1)
            `CHK(addressed, m_addr)
            q = 8'hXX;
            if (k % 4 == 0 && got_cmd.size() == 1) q = got_cmd.pop_front();
            if (k % 4 == 1 && got_wr.size() == 1) q = got_wr.pop_front();
            case (k % 4)
                0: `CHK(q, b)
                1: `CHK(q, b)
                2: `CHK(rsp_byte, b)
                default: `CHK(rsp_byte, ~b)
            endcase
        end
        abort();
        `CHK(addressed, m_addr)
        @(posedge i_clock);
        irq_set <= 1'b1;
        @(posedge i_clock);
        irq_set <= 1'b0;
        repeat (8) @(posedge i_clock);
        #1;
        `CHK(attention, 1'b1)
        `CHK(irq_pending, 1'b1)
        op(bioh_pkg::BIOH_OP_ACK, 8'h00, 0, 60);
        `CHK(ok, 1'b1)
        `CHK(rsp_byte, DEV)
        repeat (6) @(posedge i_clock);
        #1;
        `CHK(attention, 1'b0)
        op(bioh_pkg::BIOH_OP_ACK, 8'h00, 0, 30);
        `CHK(ok, 1'b0)
        `CHK(bus_if.ack_out, 1'b1)
        abort();
        summarize();
    end
endmodule // tb_byte_io_bus_handshake
